// File: clk_pins_pkg.sv
package clk_pins_pkg;
	localparam int NUM_OUTPUTS = 10;
	localparam int NUM_INPUTS = 4;
	localparam int SEL_W = 2;
	localparam int STEP_W = 16;
	localparam int FREQ_W = 32;
	localparam int ADDR_W = 7;
	localparam int ADDR_BIT0_POS = 0;
	localparam int ADDR_BIT1_POS = 1;
	localparam logic [FREQ_W-1:0] FREQ_WORD_RESET = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] BASE_ADDR_RESET = 7'h74;
	typedef enum logic [2:0]
	{
		ST_RESET = 3'b001,
		ST_RUN = 3'b010,
		ST_REALIGN = 3'b100
	} out_state_t;
endpackage : clk_pins_pkg

// File: clk_pins_ctrl.sv
`timescale 1ns/1ps
module clk_pins_ctrl
	import clk_pins_pkg::*;
#(
	parameter int N_OUT = NUM_OUTPUTS
)
(
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic clk_en_in,
	input wire logic device_reset_n_in,
	input wire logic host_port_sel_in,
	input wire logic addr_bit0_or_chip_sel_n_in,
	input wire logic addr_bit1_in,
	input wire logic serial_data_drive_in,
	input wire logic serial_data_oe_in,
	input wire logic [ADDR_W-1:0] base_addr_in,
	input wire logic status_change_in,
	input wire logic status_ack_in,
	input wire logic output_disable_pin_in,
	input wire logic main_pll_locked_in,
	input wire logic xtal_loss_in,
	input wire logic divider_realign_n_in,
	input wire logic freq_step_down_in,
	input wire logic freq_step_up_in,
	input wire logic [3:0] step_target_in,
	input wire logic [STEP_W-1:0] step_size_in,
	input wire logic manual_sel_mode_in,
	input wire logic [SEL_W-1:0] in_sel_in,
	input wire logic [SEL_W-1:0] auto_sel_in,
	output logic two_wire_mode_out,
	output logic [ADDR_W-1:0] bus_addr_out,
	output logic spi_selected_out,
	output logic addr_bit1_or_serial_out_out,
	output logic addr_bit1_or_serial_out_oe_out,
	output logic status_change_irq_n_out,
	output logic [N_OUT-1:0] out_enable_out,
	output logic pll_lock_status_out,
	output logic xtal_signal_loss_n_out,
	output logic divider_reset_out,
	output logic [NUM_INPUTS-1:0] ref_select_out,
	output logic [FREQ_W-1:0] freq_word_out[N_OUT]
);
	logic in_reset;
	logic pending;
	logic up_q;
	logic dn_q;
	out_state_t state;
	out_state_t next_state;

	function automatic logic [NUM_INPUTS-1:0] sel_decode(input logic [SEL_W-1:0] s);
		sel_decode = '0;
		sel_decode[s] = 1'b1;
	endfunction : sel_decode

	wire two_wire = host_port_sel_in;
	wire up_rise = freq_step_up_in & ~up_q;
	wire dn_rise = freq_step_down_in & ~dn_q;
	wire [SEL_W-1:0] sel_now = manual_sel_mode_in ? in_sel_in : auto_sel_in;
	// Gating on the pin itself closes the outputs at the first edge of a device reset
	wire outs_allowed = device_reset_n_in & ~in_reset & ~output_disable_pin_in;
	wire [ADDR_W-1:0] next_addr = {base_addr_in[ADDR_W-1:2], addr_bit1_in,
		addr_bit0_or_chip_sel_n_in};

	always_comb
	begin
		case (state)
			// A realign request held across a device reset keeps the dividers parked
			ST_RESET: next_state = divider_realign_n_in ? ST_RUN : ST_REALIGN;
			ST_RUN: next_state = divider_realign_n_in ? ST_RUN : ST_REALIGN;
			ST_REALIGN: next_state = divider_realign_n_in ? ST_RUN : ST_REALIGN;
			default: next_state = ST_RESET;
		endcase
	end

	// Device reset pin is a synchronous soft reset; rst_b_in is the power-on path
	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			in_reset <= 1'b1;
			state <= ST_RESET;
			pending <= 1'b0;
			up_q <= 1'b0;
			dn_q <= 1'b0;
			two_wire_mode_out <= 1'b1;
			bus_addr_out <= BASE_ADDR_RESET;
			spi_selected_out <= 1'b0;
			addr_bit1_or_serial_out_out <= 1'b0;
			addr_bit1_or_serial_out_oe_out <= 1'b0;
			status_change_irq_n_out <= 1'b1;
			out_enable_out <= '0;
			pll_lock_status_out <= 1'b0;
			xtal_signal_loss_n_out <= 1'b1;
			divider_reset_out <= 1'b1;
			ref_select_out <= '0;
			for (int i = 0; i < N_OUT; i++)
			begin
				freq_word_out[i] <= FREQ_WORD_RESET;
			end
		end
		else if (clk_en_in)
		begin
			in_reset <= ~device_reset_n_in;
			two_wire_mode_out <= two_wire;
			bus_addr_out <= next_addr;
			spi_selected_out <= ~two_wire & ~addr_bit0_or_chip_sel_n_in & device_reset_n_in;
			addr_bit1_or_serial_out_out <= serial_data_drive_in;
			addr_bit1_or_serial_out_oe_out <= ~two_wire & ~addr_bit0_or_chip_sel_n_in
				& serial_data_oe_in;
			pll_lock_status_out <= main_pll_locked_in;
			xtal_signal_loss_n_out <= ~xtal_loss_in;
			ref_select_out <= sel_decode(sel_now);
			out_enable_out <= {N_OUT{outs_allowed}};
			if (!device_reset_n_in)
			begin
				state <= ST_RESET;
				pending <= 1'b0;
				up_q <= 1'b0;
				dn_q <= 1'b0;
				status_change_irq_n_out <= 1'b1;
				divider_reset_out <= 1'b1;
				for (int i = 0; i < N_OUT; i++)
				begin
					freq_word_out[i] <= FREQ_WORD_RESET;
				end
			end
			else
			begin
				state <= next_state;
				up_q <= freq_step_up_in;
				dn_q <= freq_step_down_in;
				// A new event beats the acknowledge in the same cycle
				pending <= status_change_in | (pending & ~status_ack_in);
				status_change_irq_n_out <= ~(status_change_in | (pending & ~status_ack_in));
				divider_reset_out <= (next_state != ST_RUN);
				for (int i = 0; i < N_OUT; i++)
				begin
					// Simultaneous up and down cancel out
					if (step_target_in == 4'(i) && (up_rise ^ dn_rise))
					begin
						if (up_rise)
							freq_word_out[i] <= freq_word_out[i] + FREQ_W'(step_size_in);
						else
							freq_word_out[i] <= freq_word_out[i] - FREQ_W'(step_size_in);
					end
				end
			end
		end
	end

	// Interrupt
	a_irq_follows_pending: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && device_reset_n_in && status_change_in |=> !status_change_irq_n_out)
		else $error("interrupt not asserted after status change");

	a_irq_held_pending: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && device_reset_n_in && !status_change_irq_n_out && !status_ack_in
		|=> !status_change_irq_n_out)
		else $error("interrupt dropped before acknowledge");

	a_irq_clear_ack: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && device_reset_n_in && status_ack_in && !status_change_in
		|=> status_change_irq_n_out)
		else $error("interrupt not released after acknowledge");

	a_irq_idle_high: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && device_reset_n_in && status_change_irq_n_out && !status_change_in
		|=> status_change_irq_n_out)
		else $error("interrupt asserted with nothing pending");

	// Device reset and output gating
	a_reset_disables_out: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && !device_reset_n_in |=> out_enable_out == '0)
		else $error("outputs enabled during device reset");

	a_dev_reset_irq: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && !device_reset_n_in |=> status_change_irq_n_out)
		else $error("interrupt not cleared by device reset");

	a_dev_reset_pend: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && !device_reset_n_in |=> !pending)
		else $error("pending status kept through device reset");

	a_dev_reset_div: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && !device_reset_n_in |=> divider_reset_out)
		else $error("dividers running during device reset");

	a_dev_reset_words: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && !device_reset_n_in |=> freq_word_out[0] == FREQ_WORD_RESET)
		else $error("first frequency word not cleared by device reset");

	a_dev_reset_last: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && !device_reset_n_in |=> freq_word_out[N_OUT-1] == FREQ_WORD_RESET)
		else $error("last frequency word not cleared by device reset");

	a_oe_pin_disables: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && output_disable_pin_in |=> out_enable_out == '0)
		else $error("outputs enabled while disable pin high");

	a_outs_run_enabled: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		rst_b_in && clk_en_in && device_reset_n_in && !in_reset && !output_disable_pin_in
		|=> out_enable_out == '1)
		else $error("outputs held off with disable pin low");

	// Status pins
	a_lock_tracks_pll: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in |=> pll_lock_status_out == $past(main_pll_locked_in))
		else $error("lock status mismatch");

	a_lock_low_unlock: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && !main_pll_locked_in |=> !pll_lock_status_out)
		else $error("lock status high while out of lock");

	a_xtal_loss_low: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && xtal_loss_in |=> !xtal_signal_loss_n_out)
		else $error("crystal loss not flagged");

	a_xtal_ok_high: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && !xtal_loss_in |=> xtal_signal_loss_n_out)
		else $error("crystal loss flagged with signal present");

	// Divider realign
	a_realign_resets_div: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && device_reset_n_in && !divider_realign_n_in |=> divider_reset_out)
		else $error("dividers not reset on realign");

	a_realign_release: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		rst_b_in && clk_en_in && device_reset_n_in && divider_realign_n_in
		|=> !divider_reset_out)
		else $error("dividers held after realign released");

	a_state_onehot: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		rst_b_in |-> $onehot(state))
		else $error("divider state not one-hot");

	// Host port pins
	a_spi_ignore_high: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && addr_bit0_or_chip_sel_n_in |=> !spi_selected_out)
		else $error("spi selected while chip select high");

	a_spi_select_low: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		rst_b_in && clk_en_in && device_reset_n_in && !host_port_sel_in
		&& !addr_bit0_or_chip_sel_n_in |=> spi_selected_out)
		else $error("spi not selected with chip select low");

	a_dev_reset_spi: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && !device_reset_n_in |=> !spi_selected_out)
		else $error("spi selected during device reset");

	a_spi_off_2wire: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && host_port_sel_in |=> !spi_selected_out)
		else $error("spi selected in two-wire mode");

	a_two_wire_sel: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		rst_b_in && clk_en_in |=> two_wire_mode_out == $past(host_port_sel_in))
		else $error("host port mode not from select pin");

	a_addr_lsb_pin: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in |=> bus_addr_out[ADDR_BIT0_POS] == $past(addr_bit0_or_chip_sel_n_in))
		else $error("address bit zero not from pin");

	a_addr_upper: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		rst_b_in && clk_en_in
		|=> bus_addr_out[ADDR_W-1:2] == $past(base_addr_in[ADDR_W-1:2]))
		else $error("upper address bits not from base");

	a_addr_bit1_pin: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		rst_b_in && clk_en_in |=> bus_addr_out[ADDR_BIT1_POS] == $past(addr_bit1_in))
		else $error("address bit one not from pin");

	a_sdo_off_2wire: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && host_port_sel_in |=> !addr_bit1_or_serial_out_oe_out)
		else $error("serial out driven in two-wire mode");

	a_sdo_off_cs: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && addr_bit0_or_chip_sel_n_in |=> !addr_bit1_or_serial_out_oe_out)
		else $error("serial out driven while chip select high");

	a_sdo_data: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		rst_b_in && clk_en_in |=> addr_bit1_or_serial_out_out == $past(serial_data_drive_in))
		else $error("serial out data not from engine");

	// Reference select
	a_manual_ref_sel: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && manual_sel_mode_in && in_sel_in == 2'h2 |=> ref_select_out == 4'h4)
		else $error("manual reference select wrong");

	a_manual_ref_any: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		rst_b_in && clk_en_in && manual_sel_mode_in
		|=> ref_select_out == (4'h1 << $past(in_sel_in)))
		else $error("manual select code maps to wrong input");

	a_auto_ref_sel: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		rst_b_in && clk_en_in && !manual_sel_mode_in
		|=> ref_select_out == (4'h1 << $past(auto_sel_in)))
		else $error("automatic reference select wrong");

	a_ref_onehot: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		rst_b_in && clk_en_in |=> $onehot(ref_select_out))
		else $error("reference select not one-hot");

	// Frequency stepping
	a_one_step_up: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && device_reset_n_in && up_rise && !dn_rise && step_target_in == 4'h0
		|=> freq_word_out[0] == $past(freq_word_out[0]) + FREQ_W'($past(step_size_in)))
		else $error("step up not applied once");

	a_one_step_down: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		clk_en_in && device_reset_n_in && dn_rise && !up_rise && step_target_in == 4'h0
		|=> freq_word_out[0] == $past(freq_word_out[0]) - FREQ_W'($past(step_size_in)))
		else $error("step down not applied once");

	a_step_other_tgt: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		rst_b_in && clk_en_in && device_reset_n_in && step_target_in != 4'h0
		|=> freq_word_out[0] == $past(freq_word_out[0]))
		else $error("step applied to an unselected output");

	// Clock enable freeze
	a_freeze_lock: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		rst_b_in && !clk_en_in |=> $stable(pll_lock_status_out))
		else $error("lock status moved while clock enable low");

	a_freeze_words: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		rst_b_in && !clk_en_in |=> $stable(freq_word_out[3]))
		else $error("frequency word moved while clock enable low");
endmodule : clk_pins_ctrl

// File: board_host.sv
`timescale 1ns/1ps
module board_host
(
	input wire logic core_clk_in,
	input wire logic up_req_in,
	input wire logic down_req_in,
	output logic freq_step_up_out = 1'b0,
	output logic freq_step_down_out = 1'b0
);
	// A request becomes one high cycle then low, so rises never merge
	always @(posedge core_clk_in)
	begin
		freq_step_up_out <= up_req_in && !freq_step_up_out;
		freq_step_down_out <= down_req_in && !freq_step_down_out;
	end
endmodule : board_host

// File: clock_gen_control_status_pins_bench.sv
`timescale 1ns/1ps
module clock_gen_control_status_pins_bench;
	import clk_pins_pkg::*;
	logic core_clk_in = 0, rst_b_in = 0, clk_en_in = 1, device_reset_n_in = 1;
	logic host_port_sel_in = 1, addr_bit0_or_chip_sel_n_in = 0, addr_bit1_in = 0;
	logic serial_data_drive_in = 1, serial_data_oe_in = 1, status_change_in = 0;
	logic status_ack_in = 0, output_disable_pin_in = 0, main_pll_locked_in = 0;
	logic xtal_loss_in = 0, divider_realign_n_in = 1, manual_sel_mode_in = 1;
	logic freq_step_down_in, freq_step_up_in, up_req = 0, dn_req = 0;
	logic [ADDR_W-1:0] base_addr_in = 7'h50, bus_addr_out;
	logic [3:0] step_target_in = 4'h3;
	logic [STEP_W-1:0] step_size_in = 16'h0010;
	logic [SEL_W-1:0] in_sel_in = 2'h0, auto_sel_in = 2'h2;
	logic two_wire_mode_out, spi_selected_out, addr_bit1_or_serial_out_out, pll_lock_status_out;
	logic addr_bit1_or_serial_out_oe_out, status_change_irq_n_out;
	logic xtal_signal_loss_n_out, divider_reset_out;
	logic [NUM_OUTPUTS-1:0] out_enable_out;
	logic [NUM_INPUTS-1:0] ref_select_out;
	logic [FREQ_W-1:0] freq_word_out[NUM_OUTPUTS];
	int miscompares, num_checks;
	clk_pins_ctrl #(.N_OUT(NUM_OUTPUTS)) clk_pins_ctrl_i(.*);
	board_host board_host_i(.core_clk_in, .up_req_in(up_req), .down_req_in(dn_req),
		.freq_step_up_out(freq_step_up_in), .freq_step_down_out(freq_step_down_in));
	always #5 core_clk_in = ~core_clk_in;
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask : wt
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	task automatic t_addr();
		addr_bit0_or_chip_sel_n_in <= 1'b1;
		wt(2);
		check(bus_addr_out, 7'h51);
		check(two_wire_mode_out, 1'b1);
		@(posedge core_clk_in);
		addr_bit0_or_chip_sel_n_in <= 1'b0;
		addr_bit1_in <= 1'b1;
		host_port_sel_in <= 1'b0;
		wt(2);
		check(spi_selected_out, 1'b1);
		check({addr_bit1_or_serial_out_oe_out, addr_bit1_or_serial_out_out}, 2'h3);
		@(posedge core_clk_in);
		addr_bit0_or_chip_sel_n_in <= 1'b1;
		wt(2);
		check({spi_selected_out, addr_bit1_or_serial_out_oe_out}, 2'h0);
	endtask : t_addr
	task automatic t_irq();
		status_change_in <= 1'b1;
		@(posedge core_clk_in);
		status_change_in <= 1'b0;
		wt(2);
		check(status_change_irq_n_out, 1'b0);
		@(posedge core_clk_in);
		status_ack_in <= 1'b1;
		@(posedge core_clk_in);
		status_ack_in <= 1'b0;
		wt(1);
		check(status_change_irq_n_out, 1'b1);
	endtask : t_irq
	task automatic t_pins(input logic v);
		output_disable_pin_in <= v;
		main_pll_locked_in <= v;
		xtal_loss_in <= v;
		divider_realign_n_in <= !v;
		wt(4);
		check(out_enable_out, {NUM_OUTPUTS{!v}});
		check(pll_lock_status_out, v);
		check(xtal_signal_loss_n_out, !v);
		check(divider_reset_out, v);
	endtask : t_pins
	// Each pulse is checked against a running total, so a missed or doubled step shows
	task automatic t_step(input logic up, input logic [3:0] tgt, input logic [31:0] exp);
		step_target_in <= tgt;
		up_req <= up;
		dn_req <= !up;
		@(posedge core_clk_in);
		up_req <= 1'b0;
		dn_req <= 1'b0;
		wt(6);
		check(freq_word_out[3], exp);
	endtask : t_step
	initial
	begin
		#50000;
		miscompares++;
		report_and_stop();
	end
	initial
	begin
		wt(6);
		check({two_wire_mode_out, bus_addr_out}, {1'b1, BASE_ADDR_RESET});
		check({status_change_irq_n_out, divider_reset_out}, 2'h3);
		@(posedge core_clk_in);
		rst_b_in <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge core_clk_in);
			in_sel_in <= SEL_W'(i);
			wt(2);
			check(ref_select_out, 4'h1 << i);
		end
		@(posedge core_clk_in);
		manual_sel_mode_in <= 1'b0;
		t_addr();
		check(ref_select_out, 4'h4);
		@(posedge core_clk_in);
		t_irq();
		@(posedge core_clk_in);
		t_pins(1'b1);
		@(posedge core_clk_in);
		t_pins(1'b0);
		@(posedge core_clk_in);
		clk_en_in <= 1'b0;
		main_pll_locked_in <= 1'b1;
		wt(3);
		check(pll_lock_status_out, 1'b0);
		@(posedge core_clk_in);
		clk_en_in <= 1'b1;
		wt(2);
		check(pll_lock_status_out, 1'b1);
		@(posedge core_clk_in);
		t_step(1'b1, 4'h3, 32'h10);
		@(posedge core_clk_in);
		t_step(1'b1, 4'h3, 32'h20);
		@(posedge core_clk_in);
		t_step(1'b0, 4'h3, 32'h10);
		@(posedge core_clk_in);
		t_step(1'b1, 4'hc, 32'h10);
		@(posedge core_clk_in);
		t_step(1'b1, 4'h0, 32'h10);
		check(freq_word_out[0], 32'h10);
		@(posedge core_clk_in);
		t_step(1'b0, 4'h0, 32'h10);
		check(freq_word_out[0], 32'h0);
		@(posedge core_clk_in);
		device_reset_n_in <= 1'b0;
		wt(3);
		check(out_enable_out, '0);
		check(freq_word_out[3], 32'h0);
		@(posedge core_clk_in);
		device_reset_n_in <= 1'b1;
		wt(4);
		check({out_enable_out, divider_reset_out}, {{NUM_OUTPUTS{1'b1}}, 1'b0});
		report_and_stop();
	end
endmodule : clock_gen_control_status_pins_bench
